// File: mpsc_chan.sv
/*
  mpsc_chan: one full-duplex serial channel with register port,
  transmit and receive fifos, line coding, loop modes and dma requests.
  assumes pins arrive asynchronous to mclk; host strobes are synchronous.
*/
// Decided for this implementation: the register addresses and the strobed register port.
// Summary of operation
// [RQ1] async receive flags parity error when parity check fails
// [RQ2] async receive flags framing error when stop bit is low
// [RQ3] sync modes flag crc error when frame check residue is wrong
// [RQ4] all modes flag overrun when byte arrives at full receive fifo
// [RQ5] overrun byte overwrites newest fifo entry, older entries kept
// [RQ6] sync transmit flags underrun when fifo empty after shift ends
// [RQ7] five line codes nrz, nrzi, fm0, fm1, manchester, both ways
// [RQ8] transmit clock from baud generator, external clock or rx clock
// [RQ9] transmit fifo holds 32 bytes before the shift register
// [RQ10] transmit shifts least significant bit first with mode framing
// [RQ11] first received bit becomes least significant bit
// [RQ12] receive bits pass shift chain ending in 8-bit stage four; here stage four takes rx_bit directly, the 3-bit chain feeds only the crc
// [RQ13] mode one divisor: async 1/64, 1/32, 1/16, 1/1; sync 1/1
// [RQ14] clock extraction samples at 8, 16 or 32 times bit rate
// [RQ15] channel raises dma requests for single-address fifo transfers
// [RQ16] dma moves whole words or single bytes
// [RQ17] every detected error is a readable status flag
// [RQ18] auto echo retransmits received bits and still receives them
// [RQ19] local loopback feeds own transmit data into the receiver
// [RQ20] error flags stay set until software clears them
// [RQ21] host or dma keeps tx fifo fed and rx fifo drained
`timescale 1ns/1ps
module mpsc_chan
  import mpsc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rxd_pin,
  input wire logic rxc_pin,
  input wire logic txc_pin,
  output logic txd_pin,
  output logic tx_dma_req,
  output logic rx_dma_req
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rxd_s_ff, rxc_s_ff, txc_s_ff;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rxd_s_ff <= 2'h3;
      rxc_s_ff <= 2'h0;
      txc_s_ff <= 2'h0;
    end else begin
      rxd_s_ff <= {rxd_s_ff[0], rxd_pin};
      rxc_s_ff <= {rxc_s_ff[0], rxc_pin};
      txc_s_ff <= {txc_s_ff[0], txc_pin};
    end
  end
  logic rxc_d_ff, txc_d_ff;
  always_ff @(posedge mclk) begin
    rxc_d_ff <= rxc_s_ff[1];
    txc_d_ff <= txc_s_ff[1];
  end
  wire rxc_rise = rxc_s_ff[1] && !rxc_d_ff;
  wire txc_rise = txc_s_ff[1] && !txc_d_ff;
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] mode1_ff, mode2_ff, clksel_ff, baud_ff, ctrl_ff;
  logic [7:0] st1_ff, st2_ff;
  wire [1:0] proto = mode1_ff[M1_PROTO_LO +: 2];
  wire [1:0] divsel = mode1_ff[M1_DIV_LO +: 2];
  wire [2:0] lcode = mode2_ff[M2_CODE_LO +: 3];
  wire [1:0] loopm = mode2_ff[M2_LOOP_LO +: 2];
  wire [1:0] smp = mode2_ff[M2_SMP_LO +: 2];
  wire is_async = (proto == PROTO_ASYNC);
  wire wr_mode1 = reg_wr && (reg_addr == ADDR_MODE1);
  wire wr_mode2 = reg_wr && (reg_addr == ADDR_MODE2);
  wire wr_clksel = reg_wr && (reg_addr == ADDR_CLKSEL);
  wire wr_st1 = reg_wr && (reg_addr == ADDR_STAT1);
  wire wr_st2 = reg_wr && (reg_addr == ADDR_STAT2);
  wire wr_tx = reg_wr && (reg_addr == ADDR_TXDATA);
  wire rd_rx = reg_rd && (reg_addr == ADDR_RXDATA);
  wire wr_baud = reg_wr && (reg_addr == ADDR_BAUD);
  wire wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode1_ff <= RST_MODE1;
      mode2_ff <= RST_MODE2;
      clksel_ff <= RST_CLKSEL;
      baud_ff <= RST_BAUD;
      ctrl_ff <= RST_CTRL;
    end else begin
      if (wr_mode1) mode1_ff <= reg_wdata;
      if (wr_mode2) mode2_ff <= reg_wdata;
      if (wr_clksel) clksel_ff <= reg_wdata;
      if (wr_baud) baud_ff <= reg_wdata;
      if (wr_ctrl) ctrl_ff <= reg_wdata;
    end
  end
  // ----------------------------------------------------------------
  // bit clock: source select, divisor, oversampling
  // ----------------------------------------------------------------
  logic [7:0] brg_cnt_ff;
  wire brg_tick = (brg_cnt_ff == 8'h00);
  always_ff @(posedge mclk) begin
    if (sys_rst) brg_cnt_ff <= RST_BAUD;
    else brg_cnt_ff <= brg_tick ? baud_ff : brg_cnt_ff - 8'h01;
  end
  // sync modes always 1/1, async uses the mode one divisor
  wire [5:0] div_m1 = !is_async ? 6'h00 : // RQ13
    (divsel == DIV_64) ? 6'h3F : (divsel == DIV_32) ? 6'h1F :
    (divsel == DIV_16) ? 6'h0F : 6'h00;
  // extraction oversampling replaces the divisor in sync modes
  wire [5:0] smp_m1 = (smp == SMP_32) ? 6'h1F : // RQ14
    (smp == SMP_16) ? 6'h0F : 6'h07;
  wire [5:0] rx_m1 = is_async ? div_m1 : smp_m1;
  wire src_tick = (clksel_ff[1:0] == CSRC_EXT) ? txc_rise : // RQ8
    (clksel_ff[1:0] == CSRC_RX) ? rxc_rise : brg_tick;
  logic [5:0] txdiv_ff;
  wire tx_bit = src_tick && (txdiv_ff == div_m1);
  always_ff @(posedge mclk) begin
    if (sys_rst) txdiv_ff <= 6'h00;
    else if (src_tick) txdiv_ff <= tx_bit ? 6'h00 : txdiv_ff + 6'h01;
  end
  // ----------------------------------------------------------------
  // transmit fifo and dma
  // ----------------------------------------------------------------
  logic tx_pop;
  wire [7:0] tx_head;
  wire [5:0] tx_cnt;
  wire tx_full, tx_empty;
  mpsc_fifo u_txf ( // RQ9
    .mclk(mclk), .sys_rst(sys_rst), .push(wr_tx && !tx_full),
    .din(reg_wdata), .pop(tx_pop), .dout(tx_head), .count(tx_cnt),
    .full(tx_full), .empty(tx_empty)
  );
  // word transfers need two free or two filled entries
  wire word_mode = ctrl_ff[CTL_WORD]; // RQ16
  wire tx_req_n = word_mode ? (tx_cnt < 6'h1F) : !tx_full; // RQ15
  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  mpsc_tx_state_t tx_st_ff;
  logic [7:0] tx_sh_ff;
  logic [2:0] tx_bc_ff;
  logic tx_raw_ff, tx_par_ff;
  wire sync_m = !is_async;
  wire tx_done = tx_bit && (tx_st_ff == TX_DATA) && (tx_bc_ff == 3'h7);
  assign tx_pop = tx_bit && !tx_empty && ctrl_ff[CTL_TXEN] &&
    ((tx_st_ff == TX_IDLE) || (sync_m && tx_done));
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_st_ff <= TX_IDLE;
      tx_sh_ff <= 8'h00;
      tx_bc_ff <= 3'h0;
      tx_raw_ff <= 1'b1;
      tx_par_ff <= 1'b0;
    end else if (tx_bit) begin
      case (tx_st_ff)
        TX_IDLE: begin
          tx_raw_ff <= sync_m ? SYNC_FLAG[tx_bc_ff] : 1'b1;
          tx_bc_ff <= sync_m ? tx_bc_ff + 3'h1 : 3'h0;
          if (tx_pop) begin
            tx_sh_ff <= tx_head;
            tx_bc_ff <= 3'h0;
            tx_st_ff <= sync_m ? TX_DATA : TX_START;
          end
        end
        TX_START: begin
          tx_raw_ff <= 1'b0;
          tx_par_ff <= mode1_ff[M1_PARODD];
          tx_st_ff <= TX_DATA;
        end
        TX_DATA: begin
          tx_raw_ff <= tx_sh_ff[0]; // RQ10
          tx_par_ff <= tx_par_ff ^ tx_sh_ff[0];
          tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
          tx_bc_ff <= tx_bc_ff + 3'h1;
          if (tx_bc_ff == 3'h7) begin
            if (sync_m && tx_pop) begin
              tx_sh_ff <= tx_head;
            end else begin
              tx_st_ff <= sync_m ? TX_IDLE : TX_STOP;
            end
          end
        end
        TX_STOP: begin
          tx_raw_ff <= mode1_ff[M1_PAREN] ? tx_par_ff : 1'b1;
          tx_par_ff <= 1'b1;
          tx_st_ff <= TX_IDLE;
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end
  wire tx_underrun = sync_m && tx_done && tx_empty; // RQ6
  // ----------------------------------------------------------------
  // line coding, shared for both directions
  // ----------------------------------------------------------------
  logic tx_lvl_ff, tx_half_ff;
  logic [5:0] tx_hcnt_ff;
  wire tx_mid = src_tick && (tx_hcnt_ff == {1'b0, div_m1[5:1]});
  always_ff @(posedge mclk) begin
    if (sys_rst) tx_hcnt_ff <= 6'h00;
    else if (tx_bit) tx_hcnt_ff <= 6'h00;
    else if (src_tick) tx_hcnt_ff <= tx_hcnt_ff + 6'h01;
  end
  // fm and manchester need a mid-bit edge, so they want a divided clock
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_lvl_ff <= 1'b1;
      tx_half_ff <= 1'b0;
    end else if (tx_bit) begin
      tx_half_ff <= 1'b0;
      case (lcode) // RQ7
        CODE_NRZI: tx_lvl_ff <= tx_raw_ff ? tx_lvl_ff : !tx_lvl_ff;
        CODE_FM0, CODE_FM1: tx_lvl_ff <= !tx_lvl_ff;
        CODE_MAN: tx_lvl_ff <= !tx_raw_ff;
        default: tx_lvl_ff <= tx_raw_ff;
      endcase
    end else if (tx_mid && !tx_half_ff) begin
      tx_half_ff <= 1'b1;
      if (((lcode == CODE_FM0) && !tx_raw_ff) ||
          ((lcode == CODE_FM1) && tx_raw_ff) || (lcode == CODE_MAN)) begin
        tx_lvl_ff <= !tx_lvl_ff; // RQ7
      end
    end
  end
  // ----------------------------------------------------------------
  // receive path and loop modes
  // ----------------------------------------------------------------
  wire rx_line = (loopm == LOOP_LOCAL) ? tx_lvl_ff : rxd_s_ff[1]; // RQ19
  logic [5:0] rx_cnt_ff;
  logic rx_prev_ff, rx_act_ff;
  wire rx_tick = is_async ? src_tick : 1'b1;
  wire rx_edge = (rx_line != rx_prev_ff);
  // mid-bit sample, realigned on every line edge for extraction
  wire rx_smp = rx_tick && (rx_cnt_ff == {1'b0, rx_m1[5:1]});
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_cnt_ff <= 6'h00;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_prev_ff <= rx_line;
      if (rx_edge && (!is_async || !rx_act_ff)) rx_cnt_ff <= 6'h00;
      else if (rx_tick) begin
        rx_cnt_ff <= (rx_cnt_ff == rx_m1) ? 6'h00 : rx_cnt_ff + 6'h01;
      end
    end
  end
  // decode: nrz/manchester direct, nrzi/fm by level comparison
  logic rx_lastlvl_ff;
  wire rx_bit = (lcode == CODE_NRZI) ? (rx_line == rx_lastlvl_ff) :
    (lcode == CODE_FM0) ? (rx_line == rx_lastlvl_ff) :
    (lcode == CODE_FM1) ? (rx_line != rx_lastlvl_ff) :
    (lcode == CODE_MAN) ? !rx_line : rx_line; // RQ7
  always_ff @(posedge mclk) begin
    if (sys_rst) rx_lastlvl_ff <= 1'b1;
    else if (rx_smp) rx_lastlvl_ff <= rx_line;
  end
  // shift chain: stages one to three delay bits for the crc only, stage four assembles straight from rx_bit
  logic [7:0] rx_st4_ff, rx_chk_ff;
  logic [2:0] rx_chain_ff;
  logic [3:0] rx_bc_ff;
  logic rx_par_ff;
  logic [15:0] crc_ff;
  wire crc_fb = crc_ff[0] ^ rx_chain_ff[2];
  wire [15:0] crc_nxt = {1'b0, crc_ff[15:1]} ^ (crc_fb ? CRC_POLY : 16'h0);
  wire rx_en = ctrl_ff[CTL_RXEN];
  wire rx_strt = is_async && !rx_act_ff && rx_smp && !rx_line;
  wire rx_shift = rx_smp && rx_act_ff && (rx_bc_ff < 4'h8);
  wire flag_seen = !is_async && (rx_chk_ff == SYNC_FLAG);
  wire rx_byte = rx_shift && (rx_bc_ff == 4'h7) && !flag_seen;
  wire par_chk = rx_smp && rx_act_ff && (rx_bc_ff == 4'h8) &&
    mode1_ff[M1_PAREN];
  wire stop_smp = rx_smp && rx_act_ff && is_async &&
    (rx_bc_ff == (mode1_ff[M1_PAREN] ? 4'h9 : 4'h8));
  always_ff @(posedge mclk) begin
    if (sys_rst || !rx_en) begin
      rx_st4_ff <= 8'h00;
      rx_chk_ff <= 8'h00;
      rx_chain_ff <= 3'h0;
      rx_bc_ff <= 4'h0;
      rx_act_ff <= 1'b0;
      rx_par_ff <= 1'b0;
      crc_ff <= CRC_INIT;
    end else if (rx_strt) begin
      rx_act_ff <= 1'b1;
      rx_bc_ff <= 4'h0;
      rx_par_ff <= mode1_ff[M1_PARODD];
    end else if (rx_smp) begin
      rx_chain_ff <= {rx_chain_ff[1:0], rx_bit}; // RQ12
      rx_chk_ff <= {rx_bit, rx_chk_ff[7:1]};
      if (!is_async) begin
        rx_act_ff <= 1'b1;
        crc_ff <= flag_seen ? CRC_INIT : crc_nxt;
      end
      if (flag_seen) rx_bc_ff <= 4'h0;
      else if (rx_shift) begin
        rx_st4_ff <= {rx_bit, rx_st4_ff[7:1]}; // RQ11
        rx_par_ff <= rx_par_ff ^ rx_bit;
        rx_bc_ff <= (!is_async && rx_bc_ff == 4'h7) ? 4'h0 : rx_bc_ff + 4'h1;
      end else if (rx_act_ff && is_async) begin
        rx_bc_ff <= rx_bc_ff + 4'h1;
        if (stop_smp) rx_act_ff <= 1'b0;
      end
    end
  end
  wire crc_bad = flag_seen && rx_smp && (crc_ff != CRC_GOOD) &&
    (crc_ff != CRC_INIT); // RQ3
  wire par_bad = par_chk && (rx_par_ff != rx_bit); // RQ1
  wire frm_bad = stop_smp && !rx_line; // RQ2
  // ----------------------------------------------------------------
  // receive fifo
  // ----------------------------------------------------------------
  logic rx_push_ff;
  logic [7:0] rx_byte_ff;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_push_ff <= 1'b0;
      rx_byte_ff <= 8'h00;
    end else begin
      rx_push_ff <= rx_byte;
      if (rx_byte) rx_byte_ff <= {rx_bit, rx_st4_ff[7:1]};
    end
  end
  wire [7:0] rx_head;
  wire [5:0] rx_cnt;
  wire rx_full, rx_empty;
  mpsc_fifo u_rxf ( // RQ5
    .mclk(mclk), .sys_rst(sys_rst), .push(rx_push_ff), .din(rx_byte_ff),
    .pop(rd_rx), .dout(rx_head), .count(rx_cnt), .full(rx_full),
    .empty(rx_empty)
  );
  wire rx_ovr = rx_push_ff && rx_full && !rd_rx; // RQ4
  wire rx_req_n = word_mode ? (rx_cnt > 6'h01) : !rx_empty; // RQ16
  // ----------------------------------------------------------------
  // sticky status, set wins over write-one-to-clear
  // ----------------------------------------------------------------
  wire [7:0] st1_set = {7'h00, tx_underrun};
  wire [7:0] st2_set = {4'h0, rx_ovr, crc_bad, frm_bad, par_bad}; // RQ17
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st1_ff <= 8'h00;
      st2_ff <= 8'h00;
    end else begin
      st1_ff <= (st1_ff & ~(wr_st1 ? reg_wdata : 8'h00)) | st1_set; // RQ20
      st2_ff <= (st2_ff & ~(wr_st2 ? reg_wdata : 8'h00)) | st2_set; // RQ20
    end
  end
  // ----------------------------------------------------------------
  // read mux and outputs
  // ----------------------------------------------------------------
  wire [7:0] rd_val =
    (reg_addr == ADDR_MODE1) ? mode1_ff :
    (reg_addr == ADDR_MODE2) ? mode2_ff :
    (reg_addr == ADDR_CLKSEL) ? clksel_ff :
    (reg_addr == ADDR_STAT1) ? st1_ff :
    (reg_addr == ADDR_STAT2) ? st2_ff :
    (reg_addr == ADDR_RXDATA) ? rx_head :
    (reg_addr == ADDR_FIFOLVL) ? {2'h0, rx_cnt} :
    (reg_addr == ADDR_BAUD) ? baud_ff :
    (reg_addr == ADDR_CTRL) ? ctrl_ff : 8'h00;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
      txd_pin <= 1'b1;
      tx_dma_req <= 1'b0;
      rx_dma_req <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_val : 8'h00;
      // echo sends the line straight back out
      txd_pin <= (loopm == LOOP_ECHO) ? rxd_s_ff[1] : tx_lvl_ff; // RQ18
      tx_dma_req <= ctrl_ff[CTL_TXEN] && tx_req_n; // RQ15
      rx_dma_req <= rx_en && rx_req_n; // RQ15
    end
  end
endmodule

// File: mpsc_pkg.sv
/*
  package for the serial channel: register offsets, field positions,
  reset values, mode encodings and fixed sizes.
  assumes a single 20 MHz clock domain and a plain strobe register port.
*/
package mpsc_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_MODE1 = 4'h0;
  localparam logic [3:0] ADDR_MODE2 = 4'h1;
  localparam logic [3:0] ADDR_CLKSEL = 4'h2;
  localparam logic [3:0] ADDR_STAT1 = 4'h3;
  localparam logic [3:0] ADDR_STAT2 = 4'h4;
  localparam logic [3:0] ADDR_TXDATA = 4'h5;
  localparam logic [3:0] ADDR_RXDATA = 4'h6;
  localparam logic [3:0] ADDR_FIFOLVL = 4'h7;
  localparam logic [3:0] ADDR_BAUD = 4'h8;
  localparam logic [3:0] ADDR_CTRL = 4'h9;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int M1_PROTO_LO = 0;  // mode1[1:0] protocol
  localparam int M1_DIV_LO = 2;    // mode1[3:2] clock divisor
  localparam int M1_PAREN = 4;     // mode1[4] parity enable
  localparam int M1_PARODD = 5;    // mode1[5] odd parity
  localparam int M2_CODE_LO = 0;   // mode2[2:0] line code
  localparam int M2_LOOP_LO = 3;   // mode2[4:3] loop mode
  localparam int M2_SMP_LO = 5;    // mode2[6:5] sampling multiple
  localparam int CTL_TXEN = 0;
  localparam int CTL_RXEN = 1;
  localparam int CTL_WORD = 2;     // dma word (two bytes) transfers
  localparam int ST1_UNDR = 0;
  localparam int ST2_PAR = 0;
  localparam int ST2_FRM = 1;
  localparam int ST2_CRC = 2;
  localparam int ST2_OVR = 3;
  // ----------------------------------------------------------------
  // reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MODE1 = 8'h00;
  localparam logic [7:0] RST_MODE2 = 8'h00;
  localparam logic [7:0] RST_CLKSEL = 8'h00;
  localparam logic [7:0] RST_BAUD = 8'h0F;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_AW = 5;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_GOOD = 16'hF0B8;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [7:0] SYNC_FLAG = 8'h7E;
  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  localparam logic [1:0] PROTO_ASYNC = 2'h0;
  localparam logic [1:0] PROTO_BYTE = 2'h1;
  localparam logic [1:0] PROTO_BIT = 2'h2;
  localparam logic [1:0] DIV_1 = 2'h0;
  localparam logic [1:0] DIV_16 = 2'h1;
  localparam logic [1:0] DIV_32 = 2'h2;
  localparam logic [1:0] DIV_64 = 2'h3;
  localparam logic [2:0] CODE_NRZ = 3'h0;
  localparam logic [2:0] CODE_NRZI = 3'h1;
  localparam logic [2:0] CODE_FM0 = 3'h2;
  localparam logic [2:0] CODE_FM1 = 3'h3;
  localparam logic [2:0] CODE_MAN = 3'h4;
  localparam logic [1:0] LOOP_NONE = 2'h0;
  localparam logic [1:0] LOOP_ECHO = 2'h1;
  localparam logic [1:0] LOOP_LOCAL = 2'h2;
  localparam logic [1:0] CSRC_BRG = 2'h0;
  localparam logic [1:0] CSRC_EXT = 2'h1;
  localparam logic [1:0] CSRC_RX = 2'h2;
  localparam logic [1:0] SMP_8 = 2'h0;
  localparam logic [1:0] SMP_16 = 2'h1;
  localparam logic [1:0] SMP_32 = 2'h2;
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA = 4'b0100,
    TX_STOP = 4'b1000
  } mpsc_tx_state_t;
endpackage

// File: mpsc_fifo.sv
/*
  mpsc_fifo: 32 x 8 synchronous fifo with count.
  assumes one clock; push while full without a pop overwrites the newest entry.
*/
`timescale 1ns/1ps
module mpsc_fifo
  import mpsc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic push,
  input wire logic [7:0] din,
  input wire logic pop,
  output logic [7:0] dout,
  output logic [5:0] count,
  output logic full,
  output logic empty
);
  logic [7:0] mem_ff [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wptr_ff;
  logic [FIFO_AW-1:0] rptr_ff;
  logic [5:0] cnt_ff;
  wire do_pop = pop && (cnt_ff != 6'h00);
  wire ovw = push && full && !do_pop;
  wire do_push = push && !full;
  wire [FIFO_AW-1:0] last_ptr = wptr_ff - 5'h01;
  assign full = (cnt_ff == 6'h20);
  assign empty = (cnt_ff == 6'h00);
  assign count = cnt_ff;
  assign dout = mem_ff[rptr_ff];
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (do_push || (push && full && do_pop)) begin
      mem_ff[wptr_ff] <= din;
    end else if (ovw) begin
      mem_ff[last_ptr] <= din; // older entries untouched
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wptr_ff <= 5'h00;
      rptr_ff <= 5'h00;
      cnt_ff <= 6'h00;
    end else begin
      if (do_push || (push && full && do_pop)) begin
        wptr_ff <= wptr_ff + 5'h01;
      end
      if (do_pop) begin
        rptr_ff <= rptr_ff + 5'h01;
      end
      if ((do_push || (push && full)) && !do_pop) begin
        cnt_ff <= full ? cnt_ff : cnt_ff + 6'h01;
      end else if (do_pop && !push) begin
        cnt_ff <= cnt_ff - 6'h01;
      end
    end
  end
endmodule

// File: mpsc_checker.sv
/* checker for mpsc_chan register port and line pins.
   assumes a bind to mpsc_chan; sees its ports only. */
`timescale 1ns/1ps
module mpsc_checker
  import mpsc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic txd_pin,
  input wire logic tx_dma_req,
  input wire logic rx_dma_req
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // any flag write forgets the flags: coarse, but never a false fire
  logic rd_st2_ff;
  logic [3:0] seen_ff;
  always_ff @(posedge mclk) begin
    rd_st2_ff <= reg_rd && reg_addr == ADDR_STAT2;
    if (sys_rst || (reg_wr && reg_addr == ADDR_STAT2)) seen_ff <= 4'h0;
    else if (rd_st2_ff) seen_ff <= reg_rdata[3:0];
  end
  property p_back(a, m);
    reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a
      |=> (reg_rdata & m) == ($past(reg_wdata, 2) & m);
  endproperty
  a_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("rdata not zero");
  a_unmapped_zero: assert property (reg_rd && reg_addr > ADDR_CTRL
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_reset_idle: assert property (disable iff (1'b0) sys_rst |=> txd_pin)
    else $error("line not idle");
  a_reset_dma: assert property (disable iff (1'b0) sys_rst |=>
    !tx_dma_req && !rx_dma_req) else $error("dma request in reset");
  a_div_back: assert property (p_back(ADDR_MODE1, 8'h3F))
    else $error("mode one readback");
  a_code_back: assert property (p_back(ADDR_MODE2, 8'h07))
    else $error("line code readback");
  a_clksel_back: assert property (p_back(ADDR_CLKSEL, 8'h03))
    else $error("clock source readback");
  a_flags_stay: assert property (rd_st2_ff |->
    (reg_rdata[3:0] & seen_ff) == seen_ff) else $error("flag lost");
  c_txdata: cover property (reg_wr && reg_addr == ADDR_TXDATA);
  c_overrun: cover property (rd_st2_ff && reg_rdata[ST2_OVR]);
  c_line_low: cover property (!txd_pin);
endmodule
bind mpsc_chan mpsc_checker chk (.mclk(mclk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txd_pin(txd_pin),
  .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));

// File: mpsc_station.sv
/* station: remote async peer on the mpsc_chan line pins.
   assumes 16 mclk a bit; its clocks stand still outside frames. */
`timescale 1ns/1ps
module mpsc_station (
  input wire logic mclk,
  input wire logic txd_pin,
  output logic rxd_pin,
  output logic rxc_pin,
  output logic txc_pin
);
  initial {rxd_pin, rxc_pin, txc_pin} = 3'b100;
  // clock rises mid-bit; txd read late so dut sync delay is covered
  task automatic beat(input logic rx, b);
    if (rx) rxd_pin <= b;
    repeat (8) @(posedge mclk);
    if (rx) rxc_pin <= 1'b1; else txc_pin <= 1'b1;
    repeat (8) @(posedge mclk);
    {rxc_pin, txc_pin} <= 2'b00;
  endtask
  task automatic send(input logic [7:0] b, input logic pe, po, bp, bs);
    beat(1'b1, 1'b0);
    for (int i = 0; i < 8; i++) beat(1'b1, b[i]);
    if (pe) beat(1'b1, ^b ^ po ^ bp);
    beat(1'b1, ~bs);
    beat(1'b1, 1'b1);
  endtask
  task automatic recv(output logic [7:0] b);
    int n = 0;
    beat(1'b0, 1'b0);
    while (txd_pin !== 1'b0 && n++ < 400) beat(1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      beat(1'b0, 1'b0);
      b[i] = txd_pin;
    end
    beat(1'b0, 1'b0);
  endtask
endmodule

// File: multiprotocol_serial_channel_bench.sv
/* bench for mpsc_chan with the line station and bound checker.
   assumes async 1/1 framing; tx on external clock, rx on rx clock. */
`timescale 1ns/1ps
module multiprotocol_serial_channel_bench;
  import mpsc_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, q, d;
  logic txd_pin, rxd_pin, rxc_pin, txc_pin, tx_dma_req, rx_dma_req;
  int errors = 0, checks = 0, cyc = 0, seed = 32'h53f35cc7;
  logic [7:0] sent [$];
  logic [3:0] ra [7] = '{ADDR_MODE1, ADDR_MODE2, ADDR_CLKSEL, ADDR_BAUD,
    ADDR_CTRL, ADDR_STAT2, 4'hF};
  logic [7:0] rv [7] = '{RST_MODE1, RST_MODE2, RST_CLKSEL, RST_BAUD,
    RST_CTRL, 8'h00, 8'h00};
  always #25 mclk = ~mclk;
  mpsc_chan dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rxd_pin(rxd_pin), .rxc_pin(rxc_pin),
    .txc_pin(txc_pin), .txd_pin(txd_pin), .tx_dma_req(tx_dma_req),
    .rx_dma_req(rx_dma_req));
  mpsc_station st (.mclk(mclk), .txd_pin(txd_pin), .rxd_pin(rxd_pin),
    .rxc_pin(rxc_pin), .txc_pin(txc_pin));
  function automatic logic [7:0] bitv(input int b);
    return 8'h01 << b;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge mclk) reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge mclk) reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic chk(input logic [7:0] g, e, input string m);
    checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // traffic needs about 7k cycles
  always @(posedge mclk) if (++cyc == 60000) begin
    errors++;
    $display("unexpected at %0t: timeout", $time);
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk) #1;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(q, rv[i], "reset value");
    end
    // last pass leaves async 1/1, external clock
    for (int c = 0; c < 5; c++) begin
      wr(ADDR_MODE2, 8'(c));
      rd(ADDR_MODE2);
      chk(q & 8'h07, 8'(c), "code");
      wr(ADDR_MODE1, 8'((c % 4) << M1_DIV_LO));
      rd(ADDR_MODE1);
      chk(q & 8'h0C, 8'((c % 4) << M1_DIV_LO), "divisor");
      wr(ADDR_CLKSEL, 8'(c % 3));
      rd(ADDR_CLKSEL);
      chk(q & 8'h03, 8'(c % 3), "clock source");
    end
    wr(ADDR_MODE2, 8'(CODE_NRZ));
    wr(ADDR_CTRL, 8'h03);
    rd(ADDR_CTRL);
    chk({7'h0, tx_dma_req}, 8'h01, "tx request");
    repeat (4) begin
      sent.push_back(8'($random(seed)));
      wr(ADDR_TXDATA, sent[$]);
    end
    repeat (4) begin
      st.recv(q);
      chk(q, sent.pop_front(), "tx byte");
    end
    // async receive samples on the selected source, so follow the rx clock
    wr(ADDR_CLKSEL, 8'(CSRC_RX));
    for (int e = 0; e < 3; e++) begin
      d = 8'($random(seed));
      wr(ADDR_MODE1, 8'h30);
      st.send(d, 1'b1, 1'b1, e == 1, e == 2);
      if (e == 0) chk({7'h0, rx_dma_req}, 8'h01, "rx request");
      rd(ADDR_STAT2);
      chk(q & 8'h0F, e == 0 ? 8'h00 : bitv(e - 1), "flag");
      rd(ADDR_STAT2);
      chk(q & 8'h0F, e == 0 ? 8'h00 : bitv(e - 1), "flag kept");
      wr(ADDR_STAT2, 8'h0F);
      rd(ADDR_RXDATA);
      if (e == 0) chk(q, d, "rx byte");
    end
    wr(ADDR_MODE2, 8'(LOOP_ECHO << M2_LOOP_LO));
    st.rxd_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    chk({7'h0, txd_pin}, 8'h00, "echo");
    st.rxd_pin <= 1'b1;
    wr(ADDR_MODE2, 8'(CODE_NRZ));
    wr(ADDR_MODE1, 8'h00);
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      sent.push_back(8'($random(seed)));
      st.send(sent[i], 1'b0, 1'b0, 1'b0, 1'b0);
    end
    rd(ADDR_STAT2);
    chk(q & bitv(ST2_OVR), bitv(ST2_OVR), "overrun");
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      rd(ADDR_RXDATA);
      chk(q, sent[i < FIFO_DEPTH - 1 ? i : FIFO_DEPTH], "fifo");
    end
    rd(ADDR_CTRL);
    chk({7'h0, rx_dma_req}, 8'h00, "rx drained");
    report_and_stop();
  end
endmodule
